/* ccev_event_logic.sv */
// Purpose: Channel error, bus error, bus-off and FIFO lost flags; wake-up and ECC pulses
// Assumes: Events are single-cycle pulses from the protocol core
// Notes: Registers on classic Wishbone slave, one-cycle ack
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`include "ccev_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ccev_event_logic (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic can_receive_pin_in,
   input wire logic bit_tick_in,
   input wire logic [1:0] channel_mode_in,
   input wire ccev_pkg::ccev_evt_t evt_in,
   input wire ccev_pkg::ccev_fifo_t fifo_in,
   output logic channel_err_irq_out,
   output logic bus_err_irq_out,
   output logic global_err_irq_out,
   output logic busoff_recov_irq_out,
   output logic wakeup_out,
   output logic ecc_irq_out,
   output logic rx_fifo_irq_out,
   output logic common_fifo_irq_out,
   output logic rx_fifo_discard_out,
   output logic common_fifo_discard_out,
   output logic halt_req_out
);
   // ************************************
   // Pin synchroniser and counters
   // ************************************
   logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
   logic [5:0] dom_cnt_reg, dom_cnt_next;
   logic [3:0] rec_cnt_reg, rec_cnt_next;
   logic [7:0] seq_cnt_reg, seq_cnt_next;
   ccev_pkg::ccev_bo_t bo_reg, bo_next;
   logic [15:0] ctrl_reg;
   logic [`CCEV_CH_FLAGS-1:0] ch_flag_reg, ch_flag_next, ch_set;
   logic [`CCEV_BUS_FLAGS-1:0] bus_flag_reg, bus_flag_next, bus_set;
   logic busoff_flag_reg, busoff_flag_next;
   logic [1:0] lost_reg, lost_next;
   logic [1:0] dom_rec;
   logic [2:0] rx_thr, cm_thr;
   logic [1:0] dis;
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_meta_reg <= 1'h1;
         rx_sync_reg <= 1'h1;
         rx_prev_reg <= 1'h1;
      end else begin
         rx_meta_reg <= can_receive_pin_in;
         rx_sync_reg <= rx_meta_reg;
         rx_prev_reg <= rx_sync_reg;
      end
   end
   wire rx_fall = rx_prev_reg & ~rx_sync_reg; // R6
   wire bit_dom = bit_tick_in & ~rx_sync_reg;
   wire bit_rec = bit_tick_in & rx_sync_reg;
   wire in_oper = (channel_mode_in == `CCEV_MODE_OPER);
   assign dom_rec = {bit_dom, bit_rec};
   // Saturate so a stuck bus sets the lock flag once per run
   wire lock_hit = in_oper && bit_dom &&
      (dom_cnt_reg == `CCEV_LOCK_BITS - 6'h1); // R1
   assign dom_cnt_next = (!in_oper || bit_rec) ? 6'h0 :
      (bit_dom && dom_cnt_reg != `CCEV_LOCK_BITS) ?
      dom_cnt_reg + 6'h1 : dom_cnt_reg;
   // ************************************
   // Bus-off recovery tracking
   // ************************************
   wire [1:0] busoff_behaviour_select = ctrl_reg[13:12];
   wire force_ret = ctrl_reg[14];
   wire in_busoff = (bo_reg == ccev_pkg::CCEV_BUSOFF);
   wire run_done = bit_rec && (rec_cnt_reg == `CCEV_RECESS_RUN - 4'h1);
   wire recov_done = in_busoff && run_done &&
      (seq_cnt_reg == `CCEV_RECOV_SEQS - 8'h1); // R15 R22
   wire early_exit = in_busoff && (force_ret ||
      channel_mode_in == `CCEV_MODE_RESET ||
      (busoff_behaviour_select == `CCEV_BOM_HALT_REQ &&
       channel_mode_in == `CCEV_MODE_HALT)); // R15 R17
   assign rec_cnt_next = (!in_busoff || bit_dom || run_done) ? 4'h0 :
      bit_rec ? rec_cnt_reg + 4'h1 : rec_cnt_reg;
   assign seq_cnt_next = !in_busoff ? 8'h0 :
      run_done ? seq_cnt_reg + 8'h1 : seq_cnt_reg;
   always_comb begin
      bo_next = bo_reg;
      unique case (bo_reg)
         ccev_pkg::CCEV_ACTIVE: begin
            if (evt_in.busoff_entry) begin
               bo_next = (busoff_behaviour_select == `CCEV_BOM_HALT_ENTRY) ?
                  ccev_pkg::CCEV_HALTED : ccev_pkg::CCEV_BUSOFF; // R16
            end
         end
         ccev_pkg::CCEV_BUSOFF: begin
            if (early_exit) begin
               bo_next = (channel_mode_in == `CCEV_MODE_HALT) ?
                  ccev_pkg::CCEV_HALTED : ccev_pkg::CCEV_ACTIVE; // R17
            end else if (recov_done || evt_in.busoff_exit) begin
               bo_next = ccev_pkg::CCEV_ACTIVE;
            end
         end
         ccev_pkg::CCEV_HALTED: begin
            if (channel_mode_in != `CCEV_MODE_HALT) begin
               bo_next = ccev_pkg::CCEV_ACTIVE;
            end
         end
      endcase
   end
   // ************************************
   // Flags, set wins over software clear
   // ************************************
   assign ch_set = {lock_hit, evt_in.arb_lost, evt_in.err_count_ovf,
      evt_in.ok_count_ovf, evt_in.delay_comp_viol}; // R1 R2 R3 R4 R5
   assign bus_set = {evt_in.ack_delim_err, evt_in.bit_zero_err,
      evt_in.bit_one_err, evt_in.crc_err, evt_in.ack_err,
      evt_in.form_err, evt_in.stuff_err, 1'h0}; // R12 R13 R14
   wire fl_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
      wb_adr_in == `CCEV_ADR_ERFL;
   wire fifo_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
      wb_adr_in == `CCEV_ADR_FIFO;
   wire ctrl_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
      wb_adr_in == `CCEV_ADR_CTRL;
   // Writing one leaves a flag alone, zero clears it
   genvar gi;
   generate
      for (gi = 0; gi < `CCEV_CH_FLAGS; gi++) begin : g_ch
         assign ch_flag_next[gi] = ch_set[gi] | (ch_flag_reg[gi] &
            ~(fl_wr & wb_sel_in[0] & ~wb_dat_in[gi])); // R21 R23
      end
      for (gi = 0; gi < `CCEV_BUS_FLAGS; gi++) begin : g_bus
         assign bus_flag_next[gi] = bus_set[gi] | (bus_flag_reg[gi] &
            ~(fl_wr & wb_sel_in[1] & ~wb_dat_in[8+gi])); // R21 R23
      end
      for (gi = 0; gi < 2; gi++) begin : g_lost
         assign lost_next[gi] = dis[gi] | (lost_reg[gi] &
            ~(fifo_wr & wb_sel_in[0] & ~wb_dat_in[gi])); // R19 R20 R21
      end
   endgenerate
   assign busoff_flag_next = recov_done | (busoff_flag_reg &
      ~(fl_wr & wb_sel_in[2] & ~wb_dat_in[16])); // R21 R22
   // ************************************
   // FIFO thresholds and discard
   // ************************************
   assign rx_thr = ctrl_reg[2:0];
   assign cm_thr = ctrl_reg[5:3];
   // Cap*(v+1)/8 rounded up; code 111 means full
   wire [7:0] rx_need = 8'(fifo_in.rx_cap) * (8'(rx_thr) + 8'h1);
   wire [7:0] cm_need = 8'(fifo_in.common_cap) * (8'(cm_thr) + 8'h1);
   wire rx_full = (fifo_in.rx_fill == fifo_in.rx_cap);
   wire cm_full = (fifo_in.common_fill == fifo_in.common_cap);
   wire rx_lvl = (rx_thr == `CCEV_THR_FULL) ? rx_full :
      ({fifo_in.rx_fill, 3'h0} >= rx_need); // R8
   wire cm_lvl = (cm_thr == `CCEV_THR_FULL) ? cm_full :
      ({fifo_in.common_fill, 3'h0} >= cm_need); // R10
   assign dis = {fifo_in.common_rx_mode & cm_full &
      evt_in.common_fifo_push, rx_full & evt_in.rx_fifo_push}; // R19 R20
   // Receive buffers overwrite in place and have no event here (R18)
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dom_cnt_reg <= 6'h0;
         rec_cnt_reg <= 4'h0;
         seq_cnt_reg <= 8'h0;
         bo_reg <= ccev_pkg::CCEV_ACTIVE;
         ch_flag_reg <= '0;
         bus_flag_reg <= '0;
         busoff_flag_reg <= 1'h0;
         lost_reg <= 2'h0;
         ctrl_reg <= 16'h0;
      end else begin
         dom_cnt_reg <= dom_cnt_next;
         rec_cnt_reg <= rec_cnt_next;
         seq_cnt_reg <= seq_cnt_next;
         bo_reg <= bo_next;
         ch_flag_reg <= ch_flag_next;
         bus_flag_reg <= bus_flag_next;
         busoff_flag_reg <= busoff_flag_next;
         lost_reg <= lost_next;
         if (ctrl_wr && wb_sel_in[0]) ctrl_reg[7:0] <= wb_dat_in[7:0];
         if (ctrl_wr && wb_sel_in[1]) ctrl_reg[15:8] <= wb_dat_in[15:8];
      end
   end
   // ************************************
   // Outputs and bus read
   // ************************************
   wire [31:0] rd_mux = (wb_adr_in == `CCEV_ADR_CTRL) ? {16'h0, ctrl_reg} :
      (wb_adr_in == `CCEV_ADR_ERFL) ? {15'h0, busoff_flag_reg,
         bus_flag_reg[7:1], 1'h0, 3'h0, ch_flag_reg} :
      (wb_adr_in == `CCEV_ADR_FIFO) ? {30'h0, lost_reg} :
      (wb_adr_in == `CCEV_ADR_STAT) ? {16'h0, 2'h0, dom_cnt_reg,
         8'(bo_reg)} : 32'h0;
   wire bus_any = ctrl_reg[6] & (|bus_flag_reg[7:1]); // R14 R23
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'h0;
         wb_dat_out <= 32'h0;
         channel_err_irq_out <= 1'h0;
         bus_err_irq_out <= 1'h0;
         global_err_irq_out <= 1'h0;
         busoff_recov_irq_out <= 1'h0;
         wakeup_out <= 1'h0;
         ecc_irq_out <= 1'h0;
         rx_fifo_irq_out <= 1'h0;
         common_fifo_irq_out <= 1'h0;
         rx_fifo_discard_out <= 1'h0;
         common_fifo_discard_out <= 1'h0;
         halt_req_out <= 1'h0;
      end else begin
         wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
         wb_dat_out <= rd_mux;
         channel_err_irq_out <= |(ch_flag_reg & ctrl_reg[11:7]); // R23
         bus_err_irq_out <= bus_any; // R12 R13
         global_err_irq_out <= |(lost_reg & {2{ctrl_reg[15]}}); // R19 R20
         busoff_recov_irq_out <= busoff_flag_reg & ctrl_reg[6]; // R22
         wakeup_out <= rx_fall; // R6
         ecc_irq_out <= evt_in.ecc_single | evt_in.ecc_double; // R7
         rx_fifo_irq_out <= rx_lvl;
         common_fifo_irq_out <= cm_lvl;
         rx_fifo_discard_out <= dis[0];
         common_fifo_discard_out <= dis[1];
         halt_req_out <= (bo_next == ccev_pkg::CCEV_HALTED); // R16 R17
      end
   end
   // ************************************
   // Checks
   // ************************************
   AST_LOCK_SET: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) lock_hit |=> ch_flag_reg[4]) // R1
      else $error("bus lock flag not set");
   AST_ARB_SET: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.arb_lost |=> ch_flag_reg[3]) // R2
      else $error("arbitration lost flag not set");
   AST_EOC_SET: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.err_count_ovf |=> ch_flag_reg[2]) // R3
      else $error("error count overflow flag not set");
   AST_SOC_SET: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.ok_count_ovf |=> ch_flag_reg[1]) // R4
      else $error("success count overflow flag not set");
   AST_TDC_SET: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.delay_comp_viol |=> ch_flag_reg[0]) // R5
      else $error("delay comp flag not set");
   AST_WAKE: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) $fell(rx_sync_reg) |=> wakeup_out) // R6
      else $error("wake-up pulse missing");
   AST_ECC: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.ecc_double |=> ecc_irq_out) // R7
      else $error("ecc request missing");
   AST_BUS_FLAGS: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) evt_in.stuff_err |=> bus_flag_reg[1]) // R14
      else $error("stuff error flag not set");
   AST_HOLD: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) ch_flag_reg[3] && !fl_wr |=> ch_flag_reg[3]) // R21
      else $error("flag dropped without write");
   AST_NO_EARLY: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) early_exit && !recov_done |=> $stable(busoff_flag_reg)
      || !busoff_flag_reg) // R15
      else $error("recovery flag set on early exit");
   AST_LOST: assert property (@(posedge sys_clk_in) disable iff
      (!rst_b_in) dis[0] |=> lost_reg[0] ##0 rx_fifo_discard_out) // R19
      else $error("receive lost flag not set");
endmodule : ccev_event_logic
`default_nettype wire

/* ccev_params.svh */
// Purpose: Constants for the CAN channel event logic
// Assumes: Wishbone classic, 32-bit data, word-aligned registers
// Notes: Offsets are word addresses
//
// Overview of operation
// R1 - Count 32 dominant bits in operation mode, set bus lock flag
// R2 - Set arbitration lost flag on every lost arbitration
// R3 - Set error count overflow flag when error counter overflows
// R4 - Set success count overflow flag when success counter overflows
// R5 - Set delay compensation violation flag on violation
// R6 - Pulse wake-up on every falling edge of receive pin, no flag
// R7 - Raise RAM ECC interrupt on single correction or double detection
// R8 - Receive FIFO threshold code v fires at (v+1)/8, 111 at full
// R9 - Software avoids fractional thresholds when receive depth code is 001
// R10 - Common FIFO threshold decodes the same way as receive FIFO
// R11 - Software avoids fractional thresholds when common depth code is 001
// R12 - Ack delimiter form error sets its flag and bus error request
// R13 - Bit zero and bit one errors set own flags, request bus error
// R14 - CRC, ack, form and stuff errors each set a flag
// R15 - Recovery flag only after 128 sequences of 11 recessive bits
// R16 - Behaviour code 01 halts at bus-off entry, no recovery flag
// R17 - Code 11 with halt request during bus-off halts, no flag
// R18 - Receive buffer overwrites old message, no interrupt
// R19 - Full receive FIFO discards message, sets lost flag, global error
// R20 - Full common FIFO in receive mode discards, sets lost flag
// R21 - Flags stay set until software writes zero
// R22 - Normal bus-off return sets recovery flag and its interrupt
// R23 - Flags set regardless of enable; request is OR of flag AND enable
`ifndef CCEV_PARAMS_SVH
`define CCEV_PARAMS_SVH
`define CCEV_ADR_CTRL 4'h0
`define CCEV_ADR_ERFL 4'h1
`define CCEV_ADR_FIFO 4'h2
`define CCEV_ADR_STAT 4'h3
`define CCEV_LOCK_BITS 6'h20
`define CCEV_RECESS_RUN 4'hb
`define CCEV_RECOV_SEQS 8'h80
`define CCEV_BOM_HALT_ENTRY 2'h1
`define CCEV_BOM_HALT_REQ 2'h3
`define CCEV_MODE_OPER 2'h0
`define CCEV_MODE_RESET 2'h1
`define CCEV_MODE_HALT 2'h2
`define CCEV_DEPTH_FOUR 3'h1
`define CCEV_THR_FULL 3'h7
`define CCEV_CH_FLAGS 5
`define CCEV_BUS_FLAGS 8
`endif

/* ccev_pkg.sv */
// Purpose: Types for the CAN channel event logic
// Assumes: Used with ccev_params.svh
// Notes: None
package ccev_pkg;
   typedef struct packed {
      logic arb_lost;
      logic err_count_ovf;
      logic ok_count_ovf;
      logic delay_comp_viol;
      logic ack_delim_err;
      logic bit_zero_err;
      logic bit_one_err;
      logic crc_err;
      logic ack_err;
      logic form_err;
      logic stuff_err;
      logic busoff_entry;
      logic busoff_exit;
      logic ecc_single;
      logic ecc_double;
      logic rx_fifo_push;
      logic common_fifo_push;
   } ccev_evt_t;
   typedef struct packed {
      logic [4:0] rx_fill;
      logic [4:0] rx_cap;
      logic [4:0] common_fill;
      logic [4:0] common_cap;
      logic common_rx_mode;
   } ccev_fifo_t;
   typedef enum logic [1:0] {
      CCEV_ACTIVE, CCEV_BUSOFF, CCEV_HALTED
   } ccev_bo_t;
endpackage : ccev_pkg

/* ccev_bus_node.sv */
// Purpose: Behavioural CAN bus node seen through the transceiver
// Assumes: Recessive is high; one bit tick per sampled bit
// Notes: Bus holds the level of the last run until the next run starts
`timescale 1ns/1ns
`default_nettype none
module ccev_bus_node (
   input wire logic clk_in,
   output logic pin_out,
   output logic tick_out
);
   int falls;
   initial begin
      pin_out = 1'b1;
      tick_out = 1'b0;
      falls = 0;
   end
   // ****************************************
   // Bit runs
   // ****************************************
   // Gap sets how slowly the bits arrive
   task automatic send(input logic level, input int n, input int gap);
      @(posedge clk_in);
      if (pin_out && !level) falls++;
      pin_out <= level;
      // Let the two-stage synchroniser settle before the first tick
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         tick_out <= 1'b1;
         @(posedge clk_in);
         tick_out <= 1'b0;
         repeat (gap) @(posedge clk_in);
      end
   endtask : send
endmodule : ccev_bus_node
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the CAN channel event logic
// Assumes: Registers reached over classic Wishbone
// Notes: Every wait is bounded; settles cover registered outputs
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, rst_b, cyc, stb, we, pin, tick, ack, halt;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, dout;
   logic [1:0] mode;
   ccev_pkg::ccev_evt_t evt;
   ccev_pkg::ccev_fifo_t fifo;
   logic ch_irq, be_irq, gl_irq, bo_irq, wake, ecc;
   logic rx_irq, cm_irq, rx_dis, cm_dis;
   int err_count, samples_checked, n_wake, n_ecc, n_dis;
   int b, e, c, t, lvl;
   ccev_event_logic ccev_event_logic_inst (
      .sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dout),
      .wb_ack_out(ack), .can_receive_pin_in(pin), .bit_tick_in(tick),
      .channel_mode_in(mode), .evt_in(evt), .fifo_in(fifo),
      .channel_err_irq_out(ch_irq), .bus_err_irq_out(be_irq),
      .global_err_irq_out(gl_irq), .busoff_recov_irq_out(bo_irq),
      .wakeup_out(wake), .ecc_irq_out(ecc), .rx_fifo_irq_out(rx_irq),
      .common_fifo_irq_out(cm_irq), .rx_fifo_discard_out(rx_dis),
      .common_fifo_discard_out(cm_dis), .halt_req_out(halt)
   );
   ccev_bus_node ccev_bus_node_inst (
      .clk_in(clk), .pin_out(pin), .tick_out(tick)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Pulse outputs are counted per high cycle
   always @(posedge clk) begin
      n_wake += int'(wake === 1'b1);
      n_ecc += int'(ecc === 1'b1);
      n_dis += int'(rx_dis === 1'b1) + int'(cm_dis === 1'b1);
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      if (k == 20) begin
         err_count++;
         summarize();
      end
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rdchk(input string what, input logic [3:0] a,
                        input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(what, exp, rdat);
   endtask : rdchk
   task automatic pulse(input logic [16:0] m);
      evt <= ccev_pkg::ccev_evt_t'(m);
      @(posedge clk);
      evt <= ccev_pkg::ccev_evt_t'(17'h0);
      repeat (3) @(posedge clk);
   endtask : pulse
   task automatic do_reset();
      rst_b <= 1'b0;
      mode <= 2'h0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask : do_reset
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      summarize();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_b, cyc, stb, we, adr, wdat, mode} = '0;
      evt = ccev_pkg::ccev_evt_t'(17'h0);
      fifo = ccev_pkg::ccev_fifo_t'(21'h0);
      {err_count, samples_checked, n_wake, n_ecc, n_dis} = '0;
      do_reset();
      rdchk("ctrl", 4'h0, 32'h0);
      rdchk("unmapped", 4'h9, 32'h0);
      // Channel then bus error events, masked first, then enabled
      for (int i = 0; i < 11; i++) begin
         b = (i < 4) ? 3 - i : 19 - i;
         e = (i < 4) ? 10 - i : 6;
         wb(1'b1, 4'h0, 32'h0);
         pulse(17'h10000 >> i);
         rdchk("flag", 4'h1, 32'h1 << b);
         chk("masked irq", 32'h0, {31'h0, ch_irq | be_irq});
         wb(1'b1, 4'h0, 32'h1 << e);
         repeat (3) @(posedge clk);
         chk("irq", 32'h1, {31'h0, (i < 4) ? ch_irq : be_irq});
         wb(1'b1, 4'h1, ~(32'h1 << b));
         rdchk("flag clear", 4'h1, 32'h0);
      end
      wb(1'b1, 4'h0, 32'h800);
      ccev_bus_node_inst.send(1'b0, 31, 4);
      ccev_bus_node_inst.send(1'b1, 2, 4);
      rdchk("lock short", 4'h1, 32'h0);
      ccev_bus_node_inst.send(1'b0, 32, 1);
      rdchk("lock", 4'h1, 32'h10);
      chk("lock irq", 32'h1, {31'h0, ch_irq});
      ccev_bus_node_inst.send(1'b1, 2, 1);
      chk("wakeups", ccev_bus_node_inst.falls, n_wake);
      pulse(17'h8);
      pulse(17'h4);
      chk("ecc", 32'h2, n_ecc);
      // Depth four is only used with the full code
      for (int v = 0; v < 9; v++) begin
         c = (v < 8) ? 16 : 4;
         t = (v < 8) ? v : 7;
         wb(1'b1, 4'h0, {26'h0, t[2:0], t[2:0]});
         for (int f = 0; f < 2; f++) begin
            lvl = (t + 1) * c / 8 - 1 + f;
            fifo <= {lvl[4:0], c[4:0], lvl[4:0], c[4:0], 1'b1};
            repeat (4) @(posedge clk);
            chk("fifo irq", {30'h0, f[0], f[0]}, {30'h0, rx_irq, cm_irq});
         end
      end
      wb(1'b1, 4'h0, 32'h8000);
      fifo <= {5'hf, 5'h10, 5'hf, 5'h10, 1'b1};
      pulse(17'h3);
      rdchk("lost early", 4'h2, 32'h0);
      fifo <= {5'h10, 5'h10, 5'h10, 5'h10, 1'b1};
      pulse(17'h3);
      chk("discards", 32'h2, n_dis);
      rdchk("lost", 4'h2, 32'h3);
      chk("global irq", 32'h1, {31'h0, gl_irq});
      wb(1'b1, 4'h2, 32'h0);
      rdchk("lost clear", 4'h2, 32'h0);
      // Early exits and halt at entry first, the full recovery last
      for (int k = 0; k < 5; k++) begin
         do_reset();
         wb(1'b1, 4'h0, k == 2 ? 32'h1040 : k == 3 ? 32'h3040 : 32'h40);
         if (k == 2) mode <= 2'h2;
         pulse(17'h20);
         if (k == 2) chk("halt", 32'h1, {31'h0, halt});
         if (k == 0) wb(1'b1, 4'h0, 32'h4040);
         mode <= (k == 1) ? 2'h1 : (k == 3) ? 2'h2 : 2'h0;
         if (k < 2) pulse(17'h10);
         ccev_bus_node_inst.send(1'b1, 11 * 128 - 1, 1);
         rdchk("recov early", 4'h1, 32'h0);
         ccev_bus_node_inst.send(1'b1, 1, 1);
         if (k == 4) pulse(17'h10);
         rdchk("recov", 4'h1, 32'(k == 4) << 16);
         chk("recov irq", 32'(k == 4), {31'h0, bo_irq});
      end
      summarize();
   end
endmodule : tb
`default_nettype wire
